/* verilog/tcs_timer_ch1.sv */
// channel-1 timer control/status block with an axi4-lite register slave
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module tcs_timer_ch1 (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // transfer controller activations by the match interrupts
  input wire logic match_a_xfer_ack,
  input wire logic match_b_xfer_ack,
  // pin and interrupt
  output logic timer_output_pin,
  output logic timer_output_en,
  output logic irq
);
  // ==========================================================
  // write channel states
  typedef enum logic [2:0] {
    TCS_W_IDLE = 3'b001,
    TCS_W_COLLECT = 3'b010,
    TCS_W_RESP = 3'b100
  } tcs_wstate_t;

  tcs_wstate_t wstate_q;        // write state
  logic have_aw_q;              // address captured
  logic have_w_q;               // data captured
  logic [7:0] awaddr_q;         // captured address
  logic [31:0] wdata_q;         // captured data
  logic [3:0] wstrb_q;          // captured strobes
  logic wr_fire;                // one-cycle register write
  logic ar_fire;                // read address taken
  logic [7:0] action_q;         // action selectors, bits 3..0 used
  logic [7:0] cmp_a_q;          // compare_a_value
  logic [7:0] cmp_b_q;          // compare_b_value
  logic [2:0] mask_q;           // interrupt mask
  logic [2:0] irq_stat_q;       // sticky interrupt status
  logic [1:0] xfer_dis_q;       // transfer_disable_select per flag (b,a)
  logic [7:0] count;            // channel_counter
  logic match_a;
  logic match_b;
  logic wrap;
  logic flag_a;
  logic flag_b;
  logic flag_ovf;
  logic [7:0] ctrl_status;      // assembled status byte
  logic rd_ctrl;                // read of the control/status word
  logic wr_ctrl;                // byte-0 write of control/status
  logic pin_q;                  // output level
  logic [2:0] evt_now;          // this cycle's events in status order (ovf, b, a)

  // ==========================================================
  // address decode helper
  function automatic logic is_reg(input logic [7:0] addr, input logic [7:0] off);
    is_reg = (addr[7:2] == off[7:2]);
  endfunction : is_reg

  function automatic logic is_mapped(input logic [7:0] addr);
    if (is_reg(addr, tcs_pkg::CTRL_STATUS_OFF)) begin
      is_mapped = 1'b1;
    end else if (is_reg(addr, tcs_pkg::COUNTER_OFF)) begin
      is_mapped = 1'b1;
    end else if (is_reg(addr, tcs_pkg::COMPARE_A_OFF)) begin
      is_mapped = 1'b1;
    end else if (is_reg(addr, tcs_pkg::COMPARE_B_OFF)) begin
      is_mapped = 1'b1;
    end else if (is_reg(addr, tcs_pkg::IRQ_STATUS_OFF)) begin
      is_mapped = 1'b1;
    end else if (is_reg(addr, tcs_pkg::IRQ_MASK_OFF)) begin
      is_mapped = 1'b1;
    end else begin
      is_mapped = is_reg(addr, tcs_pkg::XFER_CTRL_OFF);
    end
  endfunction : is_mapped

  // ==========================================================
  // write path: address and data taken in either order
  assign wr_fire = (wstate_q == TCS_W_COLLECT) && have_aw_q && have_w_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate_q <= TCS_W_IDLE;
      have_aw_q <= 1'b0;
      have_w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tcs_pkg::RESP_OKAY;
    end else begin
      case (wstate_q)
        // open both ready lines
        TCS_W_IDLE: begin
          s_axi_awready <= 1'b1;
          s_axi_wready <= 1'b1;
          wstate_q <= TCS_W_COLLECT;
        end
        // collect halves; write happens once both present
        TCS_W_COLLECT: begin
          if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q <= s_axi_awaddr;
            have_aw_q <= 1'b1;
            s_axi_awready <= 1'b0;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            have_w_q <= 1'b1;
            s_axi_wready <= 1'b0;
          end
          if (wr_fire) begin
            have_aw_q <= 1'b0;
            have_w_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_mapped(awaddr_q) ? tcs_pkg::RESP_OKAY : tcs_pkg::RESP_SLVERR;
            wstate_q <= TCS_W_RESP;
          end
        end
        // hold response until accepted
        TCS_W_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wstate_q <= TCS_W_IDLE;
          end
        end
        default: begin
          wstate_q <= TCS_W_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // read path: one read at a time, data one cycle after address
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  // arming is on the read of the status word itself
  assign rd_ctrl = ar_fire && is_reg(s_axi_araddr, tcs_pkg::CTRL_STATUS_OFF);
  assign wr_ctrl = wr_fire && wstrb_q[0] && is_reg(awaddr_q, tcs_pkg::CTRL_STATUS_OFF);

  // status byte as software sees it
  always_comb begin
    ctrl_status = {flag_b, flag_a, flag_ovf, 1'b0, action_q[3:0]};
    ctrl_status[tcs_pkg::RESERVED_ONE_BIT] = tcs_pkg::CTRL_STATUS_RST[tcs_pkg::RESERVED_ONE_BIT];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= tcs_pkg::RESP_OKAY;
    end else if (s_axi_rvalid) begin
      // wait for acceptance, then reopen
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (ar_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= tcs_pkg::RESP_OKAY;
      if (is_reg(s_axi_araddr, tcs_pkg::CTRL_STATUS_OFF)) begin
        s_axi_rdata <= {24'h000000, ctrl_status};
      end else if (is_reg(s_axi_araddr, tcs_pkg::COUNTER_OFF)) begin
        s_axi_rdata <= {24'h000000, count};
      end else if (is_reg(s_axi_araddr, tcs_pkg::COMPARE_A_OFF)) begin
        s_axi_rdata <= {24'h000000, cmp_a_q};
      end else if (is_reg(s_axi_araddr, tcs_pkg::COMPARE_B_OFF)) begin
        s_axi_rdata <= {24'h000000, cmp_b_q};
      end else if (is_reg(s_axi_araddr, tcs_pkg::IRQ_STATUS_OFF)) begin
        s_axi_rdata <= {29'h00000000, irq_stat_q};
      end else if (is_reg(s_axi_araddr, tcs_pkg::IRQ_MASK_OFF)) begin
        s_axi_rdata <= {29'h00000000, mask_q};
      end else if (is_reg(s_axi_araddr, tcs_pkg::XFER_CTRL_OFF)) begin
        s_axi_rdata <= {30'h00000000, xfer_dis_q};
      end else begin
        // unmapped: zero data, slave error
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= tcs_pkg::RESP_SLVERR;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // software-owned registers, byte lane 0 only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      action_q <= 8'h00;
      cmp_a_q <= tcs_pkg::COMPARE_RST;
      cmp_b_q <= tcs_pkg::COMPARE_RST;
      mask_q <= 3'h0;
      xfer_dis_q <= 2'h0;
    end else if (wr_fire && wstrb_q[0]) begin
      if (is_reg(awaddr_q, tcs_pkg::CTRL_STATUS_OFF)) begin
        // only the action pairs store; bit four is read-only
        action_q <= {4'h0, wdata_q[3:0]};
      end else if (is_reg(awaddr_q, tcs_pkg::COMPARE_A_OFF)) begin
        cmp_a_q <= wdata_q[7:0];
      end else if (is_reg(awaddr_q, tcs_pkg::COMPARE_B_OFF)) begin
        cmp_b_q <= wdata_q[7:0];
      end else if (is_reg(awaddr_q, tcs_pkg::IRQ_MASK_OFF)) begin
        mask_q <= wdata_q[2:0];
      end else if (is_reg(awaddr_q, tcs_pkg::XFER_CTRL_OFF)) begin
        xfer_dis_q <= wdata_q[1:0];
      end
    end
  end

  // ==========================================================
  // counter and compare logic
  tcs_counter u_counter (
    .aclk(aclk),
    .aresetn(aresetn),
    .load_en(wr_fire && wstrb_q[0] && is_reg(awaddr_q, tcs_pkg::COUNTER_OFF)),
    .load_val(wdata_q[7:0]),
    .cmp_a(cmp_a_q),
    .cmp_b(cmp_b_q),
    .count_q(count),
    .match_a(match_a),
    .match_b(match_b),
    .wrap(wrap)
  );

  // ==========================================================
  // status flags; a written one is simply not a clear
  // ones ignored on flag bits
  // transfer ack clears when disable select is zero
  tcs_flag u_flag_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_evt(match_b),
    .rd_seen(rd_ctrl),
    .wr_zero(wr_ctrl && !wdata_q[tcs_pkg::MATCH_B_FLAG_BIT]),
    .auto_clr(match_b_xfer_ack && !xfer_dis_q[1]),
    .flag_q(flag_b)
  );

  tcs_flag u_flag_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_evt(match_a),
    .rd_seen(rd_ctrl),
    .wr_zero(wr_ctrl && !wdata_q[tcs_pkg::MATCH_A_FLAG_BIT]),
    .auto_clr(match_a_xfer_ack && !xfer_dis_q[0]),
    .flag_q(flag_a)
  );

  tcs_flag u_flag_ovf (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_evt(wrap),
    .rd_seen(rd_ctrl),
    .wr_zero(wr_ctrl && !wdata_q[tcs_pkg::OVERFLOW_FLAG_BIT]),
    .auto_clr(1'b0),
    .flag_q(flag_ovf)
  );

  // ==========================================================
  // interrupt status: sticky, write one to clear, set wins
  // events gathered into a vector so the loop can index them
  assign evt_now = {wrap, match_b, match_a};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= 3'h0;
    end else begin
      for (int i = 0; i < tcs_pkg::EVT_W; i++) begin
        if (evt_now[i]) begin
          irq_stat_q[i] <= 1'b1;
        end else if (wr_fire && wstrb_q[0] && is_reg(awaddr_q, tcs_pkg::IRQ_STATUS_OFF)
                     && wdata_q[i]) begin
          irq_stat_q[i] <= 1'b0;
        end
      end
    end
  end

  // registered so the pin is a flop; a set mask bit silences its event
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & ~mask_q);
    end
  end

  // ==========================================================
  // timer output; on coincident match b's action is applied to the level a's action leaves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= 1'b0;
    end else if (match_a && match_b) begin
      pin_q <= tcs_pkg::apply_action(action_q[3:2],
                                     tcs_pkg::apply_action(action_q[1:0], pin_q));
    end else if (match_b) begin
      pin_q <= tcs_pkg::apply_action(action_q[tcs_pkg::MATCH_B_ACT_HI -: 2], pin_q);
    end else if (match_a) begin
      pin_q <= tcs_pkg::apply_action(action_q[tcs_pkg::MATCH_A_ACT_HI -: 2], pin_q);
    end
  end

  // enable and level registered together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_output_en <= 1'b0;
      timer_output_pin <= 1'b0;
    end else begin
      timer_output_en <= |action_q[3:0];
      timer_output_pin <= pin_q;
    end
  end
endmodule : tcs_timer_ch1

/* verilog/tcs_pkg.sv */
// constants for the channel-1 timer control/status block
package tcs_pkg;
  // ==========================================================
  // register map (byte addresses, one aligned word each)
  localparam logic [7:0] CTRL_STATUS_OFF = 8'h00; // channel1_timer_control_status
  localparam logic [7:0] COUNTER_OFF = 8'h04;     // channel_counter
  localparam logic [7:0] COMPARE_A_OFF = 8'h08;   // compare_a_value
  localparam logic [7:0] COMPARE_B_OFF = 8'h0c;   // compare_b_value
  localparam logic [7:0] IRQ_STATUS_OFF = 8'h10;  // sticky event bits, write one to clear
  localparam logic [7:0] IRQ_MASK_OFF = 8'h14;    // interrupt mask, same layout
  localparam logic [7:0] XFER_CTRL_OFF = 8'h18;   // transfer disable select
  // ==========================================================
  // field positions of the control/status register
  localparam int MATCH_B_FLAG_BIT = 7;
  localparam int MATCH_A_FLAG_BIT = 6;
  localparam int OVERFLOW_FLAG_BIT = 5;
  localparam int RESERVED_ONE_BIT = 4;
  localparam int MATCH_B_ACT_HI = 3;
  localparam int MATCH_A_ACT_HI = 1;
  // field positions of the interrupt status / mask registers
  localparam int EVT_MATCH_A = 0;
  localparam int EVT_MATCH_B = 1;
  localparam int EVT_OVERFLOW = 2;
  localparam int EVT_W = 3;
  // ==========================================================
  // reset values and the counter maximum
  localparam logic [7:0] CTRL_STATUS_RST = 8'h10;  // reserved bit reads one
  localparam logic [7:0] COUNTER_RST = 8'h00;
  localparam logic [7:0] COMPARE_RST = 8'hff;
  localparam logic [7:0] COUNTER_MAX = 8'hff;
  // ==========================================================
  // output action codes
  localparam logic [1:0] ACT_KEEP = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // next pin level for one compare match under one action pair
  function automatic logic apply_action(input logic [1:0] act, input logic cur);
    case (act)
      ACT_LOW: apply_action = 1'b0;
      ACT_HIGH: apply_action = 1'b1;
      ACT_TOGGLE: apply_action = ~cur;
      default: apply_action = cur;
    endcase
  endfunction : apply_action
endpackage : tcs_pkg

/* verilog/tcs_flag.sv */
// one sticky status flag with read-then-write-zero clearing
`timescale 1ns/1ps
module tcs_flag (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic set_evt,   // hardware event
  input wire logic rd_seen,   // register read in progress
  input wire logic wr_zero,   // software write with zero in this bit
  input wire logic auto_clr,  // transfer-controller clear
  output logic flag_q
);
  // ==========================================================
  // arming: a zero-write clears only after the flag was read as one
  logic armed_q;

  // arm on a read that sees one, disarm once used or flag drops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_q <= 1'b0;
    end else if (rd_seen && flag_q) begin
      armed_q <= 1'b1;
    end else if (wr_zero || !flag_q) begin
      armed_q <= 1'b0;
    end
  end

  // flag state; set beats any clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else if (set_evt) begin
      flag_q <= 1'b1;
    end else if ((wr_zero && armed_q) || auto_clr) begin
      flag_q <= 1'b0;
    end
  end
endmodule : tcs_flag

/* verilog/tcs_counter.sv */
// free-running 8-bit channel counter with match and wrap strobes
`timescale 1ns/1ps
module tcs_counter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load_en,         // software write to the counter
  input wire logic [7:0] load_val,
  input wire logic [7:0] cmp_a,
  input wire logic [7:0] cmp_b,
  output logic [7:0] count_q,
  output logic match_a,             // one-cycle pulse, last cycle of equality
  output logic match_b,
  output logic wrap
);
  // ==========================================================
  // counting; strobes fire as the counter leaves the matching value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= tcs_pkg::COUNTER_RST;
    end else if (load_en) begin
      count_q <= load_val;
    end else begin
      count_q <= count_q + 8'h01;
    end
  end

  // match is combinational so the flag sets on the same edge the count moves
  always_comb begin
    match_a = !load_en && (count_q == cmp_a);
    match_b = !load_en && (count_q == cmp_b);
    wrap = !load_en && (count_q == tcs_pkg::COUNTER_MAX);
  end
endmodule : tcs_counter

/* verif/tcs_timer_ch1_assertions.sv */
// port-level checker for the channel-1 timer control/status block
`timescale 1ns/1ps
module tcs_timer_ch1_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_output_pin,
  input wire logic timer_output_en
);
  // ==========================================================
  // one clock domain, reset disables everything
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write halves taken at one edge
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // read address taken
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // ==========================================================
  // bus handshakes
  a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_write_refused: assert property (s_wr_take |=> !s_axi_awready && !s_axi_wready)
    else $error("second write accepted");
  a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_stable: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data moved while waiting");
  a_unmapped_read: assert property (s_rd_take ##0 (s_axi_araddr > 8'h1b)
    |=> s_axi_rresp == tcs_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  // ==========================================================
  // register and pin behaviour
  a_reserved_one: assert property (
    s_rd_take ##0 (s_axi_araddr == tcs_pkg::CTRL_STATUS_OFF)
    |=> s_axi_rdata[4] && s_axi_rdata[31:8] == 24'h0)
    else $error("reserved bit not one");
  a_out_off_zero: assert property (
    s_wr_take ##0 (s_axi_awaddr == 8'h00 && s_axi_wdata[3:0] == 4'h0)
    |-> ##[1:3] !timer_output_en)
    else $error("output stays enabled");
  a_out_on_set: assert property (
    s_wr_take ##0 (s_axi_awaddr == 8'h00 && s_axi_wdata[3:0] != 4'h0)
    |-> ##[1:3] timer_output_en)
    else $error("output not enabled");
  a_reset_pin_low: assert property (
    $rose(aresetn) |-> !timer_output_pin && !timer_output_en)
    else $error("pin active after reset");
endmodule : tcs_timer_ch1_chk

bind tcs_timer_ch1 tcs_timer_ch1_chk u_chk (.*);

/* verif/tcs_timer_ch1_bench.sv */
// self-checking bench for the channel-1 timer control/status block
`timescale 1ns/1ps
module tcs_timer_ch1_bench;
  // ==========================================================
  // design inputs, all valued at time zero
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf; // whole word always written
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic match_a_xfer_ack = 1'b0;
  logic match_b_xfer_ack = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic timer_output_pin, timer_output_en, irq;
  int n_fail = 0;
  int n_compared = 0;
  logic [31:0] rd_v; // last read word
  logic [1:0] rsp; // last response code
  // action setting, then pin after match A and after match B
  logic [7:0] cfg [3] = '{8'h06, 8'h09, 8'h03};
  logic [1:0] exp_pin [3] = '{2'b10, 2'b01, 2'b00};

  always #2.5 aclk = ~aclk;

  tcs_timer_ch1 uut (.*);

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic gap(input int n);
    repeat (n) @(posedge aclk);
  endtask : gap

  // write: both halves offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd_v = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  // ==========================================================
  // main sequence; counter reloads keep matches far from checks
  initial begin
    gap(8);
    aresetn <= 1'b1;
    gap(2);
    chk({29'h0, irq, timer_output_pin, timer_output_en}, 32'h0);
    rd(8'h00); chk(rd_v, 32'h10);
    rd(8'h08); chk(rd_v, 32'hff);
    rd(8'h1c); chk({rd_v[29:0], rsp}, {30'h0, tcs_pkg::RESP_SLVERR});
    wr(8'h1c, 8'h00); chk({30'h0, rsp}, {30'h0, tcs_pkg::RESP_SLVERR});
    wr(8'h14, 8'h07); chk({30'h0, rsp}, {30'h0, tcs_pkg::RESP_OKAY});
    wr(8'h08, 8'h40);
    wr(8'h0c, 8'hc0);
    gap(300);
    chk({31'h0, irq}, 32'h0); // masked events stay quiet
    wr(8'h00, 8'h00); rd(8'h00); chk(rd_v, 32'hf0);
    wr(8'h00, 8'hef); rd(8'h00); chk(rd_v, 32'hff);
    wr(8'h04, 8'h00); wr(8'h00, 8'h00); rd(8'h00); chk(rd_v, 32'h10);
    gap(3); chk({31'h0, timer_output_en}, 32'h0);
    // interrupt: raise, unmask, clear
    wr(8'h04, 8'h00); rd(8'h10); chk(rd_v, 32'h7);
    wr(8'h14, 8'h00); gap(3); chk({31'h0, irq}, 32'h1);
    wr(8'h10, 8'h07); rd(8'h10); chk(rd_v, 32'h0);
    gap(2); chk({31'h0, irq}, 32'h0);
    wr(8'h14, 8'h07);
    // transfer-controller clear, b side disabled
    gap(300);
    wr(8'h18, 8'h02);
    wr(8'h04, 8'h00);
    match_a_xfer_ack <= 1'b1;
    match_b_xfer_ack <= 1'b1;
    @(posedge aclk);
    match_a_xfer_ack <= 1'b0;
    match_b_xfer_ack <= 1'b0;
    rd(8'h00); chk(rd_v, 32'hb0);
    // pin actions: high/low, low/high, toggle/keep
    for (int i = 0; i < 3; i++) begin
      wr(8'h04, 8'h00);
      wr(8'h00, cfg[i]);
      gap(100);
      chk({30'h0, timer_output_pin, timer_output_en}, {30'h0, exp_pin[i][1], 1'b1});
      gap(110);
      chk({31'h0, timer_output_pin}, {31'h0, exp_pin[i][0]});
    end
    // armed zero-write lands on the edge where match A sets (load edge + 4)
    wr(8'h08, 8'h03); rd(8'h00); wr(8'h04, 8'h00); wr(8'h00, 8'h00);
    rd(8'h00); chk({31'h0, rd_v[6]}, 32'h1);
    wr(8'h00, 8'h00); gap(3); chk({31'h0, timer_output_en}, 32'h0);
    conclude();
  end

  // hang guard, well above the expected run
  initial begin
    gap(20000);
    n_fail++;
    $display("mismatch at %0t: timeout", $time);
    conclude();
  end
endmodule : tcs_timer_ch1_bench
